// ### logic/ccptsb_pkg.sv
// Shared constants and carriers for the dual capture/compare/PWM block
package ccptsb_pkg;
  // ************************************************************
  // Channel mode codes
  // ************************************************************
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] MODE_TOGGLE = 4'h2;
  localparam logic [3:0] MODE_CAP_FALL = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE = 4'h5;
  localparam logic [3:0] MODE_CAP_R4 = 4'h6;
  localparam logic [3:0] MODE_CAP_R16 = 4'h7;
  localparam logic [3:0] MODE_SET_HI = 4'h8;
  localparam logic [3:0] MODE_SET_LO = 4'h9;
  localparam logic [3:0] MODE_SOFT = 4'ha;
  localparam logic [3:0] MODE_SPECIAL = 4'hb;
  localparam logic [1:0] MODE_CAP_TOP = 2'h1;
  localparam logic [1:0] MODE_CMP_TOP = 2'h2;
  localparam logic [1:0] MODE_PWM_TOP = 2'h3;
  // ************************************************************
  // Field positions and masks
  // ************************************************************
  localparam int DUTY_LSB_POS = 4;
  localparam int MODE_POS = 0;
  localparam logic [7:0] CTRL_RMASK = 8'h3f;
  localparam logic [3:0] EDGE_R4_LAST = 4'h3;
  localparam logic [3:0] EDGE_R16_LAST = 4'hf;
  localparam int CHAN_N = 2;
  // ************************************************************
  // Timing, prescale and steering
  // ************************************************************
  localparam int OSC_PER_TICK = 4;
  localparam int DB_OSC_PER_UNIT = 4;
  localparam logic [3:0] PRE_LIM_1 = 4'h0;
  localparam logic [3:0] PRE_LIM_4 = 4'h3;
  localparam logic [3:0] PRE_LIM_16 = 4'hf;
  localparam logic [1:0] STEER_SINGLE = 2'h0;
  localparam logic [1:0] STEER_FWD = 2'h1;
  localparam logic [1:0] STEER_HALF = 2'h2;
  localparam logic [1:0] STEER_REV = 2'h3;
  // ************************************************************
  // Carriers and state
  // ************************************************************
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] high;
    logic [7:0] low;
  } ccptsb_regs_t;
  typedef struct packed {
    logic a;
    logic b;
    logic c;
    logic d;
  } ccptsb_bridge_t;
  typedef struct packed {
    ccptsb_regs_t regs;
    logic [9:0] duty;
    logic flag;
    logic pin;
    logic pin_d;
    logic eq_d;
    logic [3:0] edges;
    logic trig;
  } ccptsb_chan_st_t;
  typedef struct packed {
    logic [3:0] pre;
    logic [9:0] fine;
    logic match;
    logic pwm_d;
    logic [8:0] db;
    ccptsb_bridge_t br;
  } ccptsb_top_st_t;
  localparam ccptsb_chan_st_t CHAN_ST_RST = '0;
  localparam ccptsb_top_st_t TOP_ST_RST = '0;
endpackage

// ### logic/ccptsb_chan.sv
// One capture/compare/PWM channel with its control and data registers
`timescale 1ns/1ps
module ccptsb_chan (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register writes
  input wire logic wr_ctrl,
  input wire logic wr_low,
  input wire logic wr_high,
  input wire logic [7:0] wdata,
  input wire logic flag_clr,
  // Time bases
  input wire logic [15:0] timer_one,
  input wire logic timer_one_async,
  input wire logic [9:0] fine_cnt,
  input wire logic period_start,
  // Pin and results
  input wire logic pin_in,
  output ccptsb_pkg::ccptsb_regs_t regs,
  output logic match_flag,
  output logic pin_out,
  output logic pin_oe,
  output logic trigger,
  output logic pwm_on
);
  ccptsb_pkg::ccptsb_chan_st_t st_reg, st_next;
  logic [3:0] mode;
  logic is_cap, is_cmp, eq, hit, rise, fall, cap_evt;
  logic [3:0] last_edge;

  // Mode decode
  assign mode = st_reg.regs.ctrl[ccptsb_pkg::MODE_POS +: 4];
  assign is_cap = mode[3:2] == ccptsb_pkg::MODE_CAP_TOP;
  assign pwm_on = mode[3:2] == ccptsb_pkg::MODE_PWM_TOP;
  assign is_cmp = mode == ccptsb_pkg::MODE_TOGGLE || mode[3:2] == ccptsb_pkg::MODE_CMP_TOP;
  // Soft and special compare leave the pin to the port
  assign pin_oe = pwm_on || (is_cmp && mode != ccptsb_pkg::MODE_SOFT
    && mode != ccptsb_pkg::MODE_SPECIAL);
  // Compare uses timer one; one event per match, not per cycle of equality
  assign eq = timer_one == {st_reg.regs.high, st_reg.regs.low};
  assign hit = is_cmp && eq && !st_reg.eq_d;
  assign rise = pin_in && !st_reg.pin_d;
  assign fall = !pin_in && st_reg.pin_d;
  assign last_edge = (mode == ccptsb_pkg::MODE_CAP_R16) ? ccptsb_pkg::EDGE_R16_LAST :
    (mode == ccptsb_pkg::MODE_CAP_R4) ? ccptsb_pkg::EDGE_R4_LAST : 4'h0;
  // Capture is blocked while timer one counts asynchronously
  assign cap_evt = is_cap && !timer_one_async && ((mode == ccptsb_pkg::MODE_CAP_FALL) ?
    fall : (rise && st_reg.edges == last_edge));

  // Next state
  always_comb begin
    st_next = st_reg;
    st_next.pin_d = pin_in;
    st_next.eq_d = eq;
    st_next.trig = 1'b0;
    if (is_cap && !timer_one_async && rise && mode != ccptsb_pkg::MODE_CAP_FALL) begin
      st_next.edges = (st_reg.edges == last_edge) ? 4'h0 : st_reg.edges + 4'h1;
    end
    if (cap_evt) begin
      {st_next.regs.high, st_next.regs.low} = timer_one;
    end
    if (hit) begin
      case (mode)
        ccptsb_pkg::MODE_TOGGLE: st_next.pin = !st_reg.pin;
        ccptsb_pkg::MODE_SET_HI: st_next.pin = 1'b1;
        ccptsb_pkg::MODE_SET_LO: st_next.pin = 1'b0;
        ccptsb_pkg::MODE_SPECIAL: st_next.trig = 1'b1;
        default: st_next.pin = st_reg.pin;
      endcase
    end
    // PWM takes its base from the fine count of timer two
    if (pwm_on) begin
      if (period_start) begin
        st_next.duty = {st_reg.regs.low, st_reg.regs.ctrl[ccptsb_pkg::DUTY_LSB_POS +: 2]};
      end
      st_next.pin = fine_cnt < st_reg.duty;
    end
    if (mode == ccptsb_pkg::MODE_OFF) begin
      st_next.pin = 1'b0;
      st_next.edges = 4'h0;
    end
    // Software writes win over a capture in the same cycle
    if (wr_low) begin
      st_next.regs.low = wdata;
    end
    if (wr_high) begin
      st_next.regs.high = wdata;
    end
    if (wr_ctrl) begin
      st_next.regs.ctrl = wdata & ccptsb_pkg::CTRL_RMASK;
      if (wdata[3:0] != mode) begin
        st_next.edges = 4'h0;
        if (wdata[3:0] == ccptsb_pkg::MODE_SET_HI) begin
          st_next.pin = 1'b0;
        end else if (wdata[3:0] == ccptsb_pkg::MODE_SET_LO) begin
          st_next.pin = 1'b1;
        end
      end
    end
    // Set wins over a clear in the same cycle
    st_next.flag = cap_evt || hit || (st_reg.flag && !flag_clr);
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= ccptsb_pkg::CHAN_ST_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign regs = st_reg.regs;
  assign match_flag = st_reg.flag;
  assign pin_out = st_reg.pin;
  assign trigger = st_reg.trig;

  // ************************************************************
  // Checks
  // ************************************************************
  property p_wr_low;
    @(posedge clk) disable iff (!rst_n) wr_low |=> regs.low == $past(wdata);
  endproperty
  a_wr_low: assert property (p_wr_low) else $error("low byte write lost");
  property p_cap_rise;
    @(posedge clk) disable iff (!rst_n)
    (mode == ccptsb_pkg::MODE_CAP_RISE && rise && !timer_one_async && !wr_low && !wr_high)
    |=> match_flag && {regs.high, regs.low} == $past(timer_one);
  endproperty
  a_cap_rise: assert property (p_cap_rise) else $error("rising capture missed");
  property p_async;
    @(posedge clk) disable iff (!rst_n)
    (timer_one_async && !wr_low && !wr_high) |=> $stable({regs.high, regs.low});
  endproperty
  a_async: assert property (p_async) else $error("capture during async count");
  property p_trig;
    @(posedge clk) disable iff (!rst_n)
    (mode == ccptsb_pkg::MODE_SPECIAL && eq && !st_reg.eq_d) |=> trigger ##1 !trigger;
  endproperty
  a_trig: assert property (p_trig) else $error("special trigger not one pulse");
  property p_duty;
    @(posedge clk) disable iff (!rst_n)
    (pwm_on && period_start && !wr_ctrl)
    |=> st_reg.duty == $past({regs.low, regs.ctrl[5:4]});
  endproperty
  a_duty: assert property (p_duty) else $error("duty not latched at period");
endmodule

// ### logic/ccptsb_top.sv
// Two capture/compare/PWM channels with shared timers and bridge steering
`timescale 1ns/1ps
module ccptsb_top (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Channel register access, index 0 is channel one
  input wire logic [1:0] ch_wr_ctrl,
  input wire logic [1:0] ch_wr_low,
  input wire logic [1:0] ch_wr_high,
  input wire logic [7:0] ch_wdata,
  input wire logic [1:0] ch_flag_clr,
  output ccptsb_pkg::ccptsb_regs_t [1:0] channel_regs,
  output logic [1:0] channel_match_flag,
  // Timer one and A/D
  input wire logic [15:0] timer_one,
  input wire logic timer_one_async,
  output logic timer_one_reset,
  output logic ad_start,
  // Timer two
  input wire logic [7:0] period_register,
  input wire logic [1:0] timer_two_prescale,
  output logic [7:0] timer_two,
  output logic timer_two_match,
  // Bridge configuration
  input wire logic [1:0] bridge_steering,
  input wire logic [6:0] deadband_delay_reg,
  // Channel one pins
  input wire logic channel_one_pin_in,
  output ccptsb_pkg::ccptsb_bridge_t bridge_out,
  output ccptsb_pkg::ccptsb_bridge_t bridge_oe,
  // Channel two pins
  input wire logic second_channel_remap_bit,
  input wire logic port_c_bit1_in,
  output logic port_c_bit1_out,
  output logic port_c_bit1_oe,
  input wire logic port_b_bit3_in,
  output logic port_b_bit3_out,
  output logic port_b_bit3_oe
);
  ccptsb_pkg::ccptsb_top_st_t st_reg, st_next;
  logic [1:0] pin_in, chan_pin, chan_oe, trig, pwm_on;
  logic [3:0] pre_lim;
  logic fine_end, per_end;
  logic [8:0] db_load;

  // ************************************************************
  // Channels
  // ************************************************************
  // Channel two input follows the remap bit
  assign pin_in = {second_channel_remap_bit ? port_c_bit1_in : port_b_bit3_in,
    channel_one_pin_in};
  // Both channels see one timer one and one timer two, so modes never mix bases
  genvar gi;
  generate
    for (gi = 0; gi < ccptsb_pkg::CHAN_N; gi++) begin : g_chan
      ccptsb_chan u_chan (
        .clk(clk),
        .rst_n(rst_n),
        .wr_ctrl(ch_wr_ctrl[gi]),
        .wr_low(ch_wr_low[gi]),
        .wr_high(ch_wr_high[gi]),
        .wdata(ch_wdata),
        .flag_clr(ch_flag_clr[gi]),
        .timer_one(timer_one),
        .timer_one_async(timer_one_async),
        .fine_cnt(st_reg.fine),
        .period_start(st_reg.match),
        .pin_in(pin_in[gi]),
        .regs(channel_regs[gi]),
        .match_flag(channel_match_flag[gi]),
        .pin_out(chan_pin[gi]),
        .pin_oe(chan_oe[gi]),
        .trigger(trig[gi]),
        .pwm_on(pwm_on[gi])
      );
    end
  endgenerate

  // Either trigger clears timer one; only channel two starts the A/D
  assign timer_one_reset = trig[0] || trig[1];
  assign ad_start = trig[1];

  // Channel two pin routing; only the pin picked by the remap bit gets the enable
  assign port_c_bit1_out = chan_pin[1];
  assign port_b_bit3_out = chan_pin[1];
  assign port_c_bit1_oe = second_channel_remap_bit && chan_oe[1];
  assign port_b_bit3_oe = !second_channel_remap_bit && chan_oe[1];

  // ************************************************************
  // Timer two and bridge
  // ************************************************************
  // Fine count: low two bits are oscillator phases within one tick
  assign pre_lim = (timer_two_prescale == 2'h0) ? ccptsb_pkg::PRE_LIM_1 :
    (timer_two_prescale == 2'h1) ? ccptsb_pkg::PRE_LIM_4 : ccptsb_pkg::PRE_LIM_16;
  assign fine_end = st_reg.pre == pre_lim;
  assign per_end = fine_end && st_reg.fine[9:2] == period_register
    && st_reg.fine[1:0] == 2'(ccptsb_pkg::OSC_PER_TICK - 1);
  assign db_load = 9'(ccptsb_pkg::DB_OSC_PER_UNIT * int'(deadband_delay_reg));

  // Next state
  always_comb begin
    st_next = st_reg;
    st_next.match = per_end;
    if (fine_end) begin
      st_next.pre = 4'h0;
      st_next.fine = per_end ? 10'h000 : st_reg.fine + 10'h001;
    end else begin
      st_next.pre = st_reg.pre + 4'h1;
    end
    st_next.pwm_d = chan_pin[0];
    st_next.db = 9'h000;
    st_next.br = '0;
    if (!pwm_on[0]) begin
      st_next.br.a = chan_pin[0];
    end else begin
      case (bridge_steering)
        ccptsb_pkg::STEER_SINGLE: st_next.br.a = chan_pin[0];
        ccptsb_pkg::STEER_HALF: begin
          // Each raw edge holds both outputs off for the dead band
          if (chan_pin[0] != st_reg.pwm_d) begin
            st_next.db = db_load;
          end else if (st_reg.db != 9'h000) begin
            st_next.db = st_reg.db - 9'h001;
          end
          st_next.br.a = chan_pin[0] && st_next.db == 9'h000;
          st_next.br.b = !chan_pin[0] && st_next.db == 9'h000;
        end
        ccptsb_pkg::STEER_FWD: begin
          st_next.br.a = 1'b1;
          st_next.br.d = chan_pin[0];
        end
        default: begin
          st_next.br.c = 1'b1;
          st_next.br.b = chan_pin[0];
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= ccptsb_pkg::TOP_ST_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // Pin enables follow the steering mode
  always_comb begin
    bridge_oe = '0;
    bridge_oe.a = chan_oe[0];
    if (pwm_on[0]) begin
      bridge_oe.b = bridge_steering != ccptsb_pkg::STEER_SINGLE;
      bridge_oe.c = bridge_steering[0];
      bridge_oe.d = bridge_steering[0];
    end
  end

  assign bridge_out = st_reg.br;
  assign timer_two = st_reg.fine[9:2];
  assign timer_two_match = st_reg.match;

  // ************************************************************
  // Checks
  // ************************************************************
  // Cycle count between matches while period settings hold still
  logic [15:0] per_cnt;
  logic cfg_ok;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      per_cnt <= 16'h0000;
      cfg_ok <= 1'b0;
    end else begin
      per_cnt <= timer_two_match ? 16'h0000 : per_cnt + 16'h0001;
      if ($changed(period_register) || $changed(timer_two_prescale)) begin
        cfg_ok <= 1'b0;
      end else if (timer_two_match) begin
        cfg_ok <= 1'b1;
      end
    end
  end
  property p_period;
    @(posedge clk) disable iff (!rst_n)
    (timer_two_match && cfg_ok && $stable(period_register) && $stable(timer_two_prescale))
    |-> per_cnt == 16'(ccptsb_pkg::OSC_PER_TICK * (int'(period_register) + 1)
      * (int'(pre_lim) + 1) - 1);
  endproperty
  a_period: assert property (p_period) else $error("PWM period length wrong");
  property p_fwd;
    @(posedge clk) disable iff (!rst_n)
    (pwm_on[0] && bridge_steering == ccptsb_pkg::STEER_FWD)
    |=> bridge_out.a && !bridge_out.b && !bridge_out.c && bridge_out.d == $past(chan_pin[0]);
  endproperty
  a_fwd: assert property (p_fwd) else $error("forward bridge pattern wrong");
  property p_rev;
    @(posedge clk) disable iff (!rst_n)
    (pwm_on[0] && bridge_steering == ccptsb_pkg::STEER_REV)
    |=> bridge_out.c && !bridge_out.a && !bridge_out.d && bridge_out.b == $past(chan_pin[0]);
  endproperty
  a_rev: assert property (p_rev) else $error("reverse bridge pattern wrong");
  property p_full;
    @(posedge clk) disable iff (!rst_n)
    (pwm_on[0] && bridge_steering[0])
    |=> $countones(bridge_out) <= 2 && (bridge_out.a != bridge_out.c);
  endproperty
  a_full: assert property (p_full) else $error("full bridge active count wrong");
  property p_half;
    @(posedge clk) disable iff (!rst_n)
    (pwm_on[0] && bridge_steering == ccptsb_pkg::STEER_HALF) |=> !(bridge_out.a && bridge_out.b);
  endproperty
  a_half: assert property (p_half) else $error("half bridge overlap");
  property p_deadband;
    @(posedge clk) disable iff (!rst_n)
    ($rose(chan_pin[0]) && pwm_on[0] && bridge_steering == ccptsb_pkg::STEER_HALF
      && deadband_delay_reg == 7'h01) |=> (!bridge_out.a)[*4];
  endproperty
  a_deadband: assert property (p_deadband) else $error("dead band too short");
  property p_remap;
    @(posedge clk) disable iff (!rst_n)
    second_channel_remap_bit |-> !port_b_bit3_oe && port_c_bit1_oe == chan_oe[1];
  endproperty
  a_remap: assert property (p_remap) else $error("channel two on wrong pin");
  property p_adc;
    @(posedge clk) disable iff (!rst_n)
    ad_start |-> timer_one_reset && $past(channel_regs[1].ctrl[3:0]) == ccptsb_pkg::MODE_SPECIAL;
  endproperty
  a_adc: assert property (p_adc) else $error("A/D start without channel two trigger");
endmodule

// ### verif/ccptsb_pin_model.sv
// Pin-side model: capture signal sources and two-way pin resolution
`timescale 1ns/1ps
module ccptsb_pin_model (
  // Source levels from the bench
  input wire logic src_one,
  input wire logic src_c,
  input wire logic src_b,
  // Design drive and enables
  input wire logic drv_one,
  input wire logic oe_one,
  input wire logic drv_c,
  input wire logic oe_c,
  input wire logic drv_b,
  input wire logic oe_b,
  // Resolved pin levels
  output logic pin_one,
  output logic pin_c,
  output logic pin_b
);
  // A driven pin shows the design, an undriven one the source
  assign pin_one = oe_one ? drv_one : src_one;
  // Direction follows the enable only, never the remap choice
  assign pin_c = oe_c ? drv_c : src_c;
  assign pin_b = oe_b ? drv_b : src_b;
endmodule

// ### verif/ccptsb_top_bench.sv
// Self-checking bench for the dual capture/compare/PWM block
`timescale 1ns/1ps
module ccptsb_top_bench;
  // ************
  // Signals
  // ************
  logic clk, rst_n, t1a, remap, s1, sc, sb;
  logic [1:0] wc, wl, wh, fc, ps, st;
  logic [7:0] wd, pr, t2;
  logic [15:0] t1;
  logic [6:0] dly;
  ccptsb_pkg::ccptsb_regs_t [1:0] rg;
  ccptsb_pkg::ccptsb_bridge_t bo, boe;
  logic [1:0] mf;
  logic tr, ad, t2m, pco, pcoe, pbo, pboe, p1, pc, pb;
  int err_count, n_tests, ca, cb, cc, cd, cp;
  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  ccptsb_top i_ccptsb_top (.clk(clk), .rst_n(rst_n), .ch_wr_ctrl(wc), .ch_wr_low(wl),
    .ch_wr_high(wh), .ch_wdata(wd), .ch_flag_clr(fc), .channel_regs(rg),
    .channel_match_flag(mf), .timer_one(t1), .timer_one_async(t1a),
    .timer_one_reset(tr), .ad_start(ad), .period_register(pr), .timer_two_prescale(ps),
    .timer_two(t2), .timer_two_match(t2m), .bridge_steering(st), .deadband_delay_reg(dly),
    .channel_one_pin_in(p1), .bridge_out(bo), .bridge_oe(boe),
    .second_channel_remap_bit(remap), .port_c_bit1_in(pc), .port_c_bit1_out(pco),
    .port_c_bit1_oe(pcoe), .port_b_bit3_in(pb), .port_b_bit3_out(pbo),
    .port_b_bit3_oe(pboe));
  ccptsb_pin_model i_ccptsb_pin_model (.src_one(s1), .src_c(sc), .src_b(sb),
    .drv_one(bo.a), .oe_one(boe.a), .drv_c(pco), .oe_c(pcoe), .drv_b(pbo),
    .oe_b(pboe), .pin_one(p1), .pin_c(pc), .pin_b(pb));
  // ************
  // Shared tasks
  // ************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: saw %h, expected %h", $time, got, exp);
    end
  endtask
  // Sampling lands 1 ns after the edge so updates have settled
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input int ch, input int k, input logic [7:0] d);
    @(posedge clk);
    wd <= d;
    wc[ch] <= (k == 0);
    wl[ch] <= (k == 1);
    wh[ch] <= (k == 2);
    @(posedge clk);
    wc <= 2'h0;
    wl <= 2'h0;
    wh <= 2'h0;
    #1;
  endtask
  task automatic pin(input int w, input logic v);
    @(posedge clk);
    if (w == 0) s1 <= v;
    else if (w == 1) sc <= v;
    else sb <= v;
    tick(3);
  endtask
  task automatic clr;
    @(posedge clk);
    fc <= 2'h3;
    @(posedge clk);
    fc <= 2'h0;
    tick(1);
  endtask
  task automatic set_t1(input logic [15:0] v);
    @(posedge clk);
    t1 <= v;
  endtask
  // Counts high cycles over a window; a full period gives the duty
  task automatic cnt(input int n);
    ca = 0;
    cb = 0;
    cc = 0;
    cd = 0;
    cp = 0;
    repeat (n) begin
      tick(1);
      ca += bo.a;
      cb += bo.b;
      cc += bo.c;
      cd += bo.d;
      cp += pco;
    end
  endtask
  task automatic per(input int exp);
    int n;
    for (n = 0; n < 300 && t2m !== 1'b1; n++) tick(1);
    for (n = 1; n < 300; n++) begin
      tick(1);
      if (t2m === 1'b1) break;
    end
    chk(16'(n), 16'(exp));
    chk(t2, 8'h00);
  endtask
  // ************
  // Scenarios
  // ************
  task automatic test_regs;
    for (int ch = 0; ch < 2; ch++) begin
      wr(ch, 0, 8'hc7);
      chk(rg[ch].ctrl, 8'h07);
      wr(ch, 1, 8'ha5);
      chk(rg[ch].low, 8'ha5);
      wr(ch, 2, 8'h5a);
      chk(rg[ch].high, 8'h5a);
      wr(ch, 0, 8'h00);
      chk(rg[ch].ctrl, 8'h00);
    end
    $display("Test regs done");
  endtask
  task automatic test_cap;
    set_t1(16'h1234);
    wr(0, 0, 8'h05);
    pin(0, 1'b1);
    chk({rg[0].high, rg[0].low}, 16'h1234);
    chk(mf[0], 1'b1);
    clr();
    chk(mf[0], 1'b0);
    @(posedge clk);
    t1a <= 1'b1;
    t1 <= 16'h4321;
    pin(0, 1'b0);
    pin(0, 1'b1);
    chk({rg[0].high, rg[0].low}, 16'h1234);
    chk(mf[0], 1'b0);
    @(posedge clk);
    t1a <= 1'b0;
    wr(0, 0, 8'h06);
    repeat (3) begin
      pin(0, 1'b0);
      pin(0, 1'b1);
    end
    chk(mf[0], 1'b0);
    pin(0, 1'b0);
    pin(0, 1'b1);
    chk(mf[0], 1'b1);
    chk({rg[0].high, rg[0].low}, 16'h4321);
    clr();
    wr(0, 0, 8'h04);
    set_t1(16'h5555);
    pin(0, 1'b0);
    chk({rg[0].high, rg[0].low}, 16'h5555);
    @(posedge clk);
    remap <= 1'b0;
    t1 <= 16'h7777;
    wr(1, 0, 8'h05);
    pin(1, 1'b1);
    chk({rg[1].high, rg[1].low}, 16'h5aa5);
    pin(2, 1'b1);
    chk({rg[1].high, rg[1].low}, 16'h7777);
    @(posedge clk);
    remap <= 1'b1;
    wr(0, 0, 8'h00);
    wr(1, 0, 8'h00);
    $display("Test capture done");
  endtask
  task automatic test_cmp;
    int ntr, nad;
    logic [7:0] m [3];
    logic [2:0] e;
    m = '{8'h08, 8'h09, 8'h02};
    e = 3'b101;
    set_t1(16'h0000);
    for (int ch = 0; ch < 2; ch++) begin
      wr(ch, 1, 8'h40);
      wr(ch, 2, 8'h00);
      wr(ch, 0, 8'h0b);
      set_t1(16'h0040);
      ntr = 0;
      nad = 0;
      repeat (6) begin
        tick(1);
        ntr += tr;
        nad += ad;
      end
      chk(16'(ntr), 16'h0001);
      chk(16'(nad), 16'(ch));
      set_t1(16'h0000);
    end
    wr(0, 0, 8'h00);
    for (int i = 0; i < 3; i++) begin
      wr(1, 0, m[i]);
      tick(1);
      chk(pco, !e[2-i]);
      clr();
      chk(mf[1], 1'b0);
      set_t1(16'h0040);
      tick(3);
      chk(pco, e[2-i]);
      chk({pcoe, pboe}, 2'h2);
      chk(mf[1], 1'b1);
      set_t1(16'h0000);
    end
    @(posedge clk);
    remap <= 1'b0;
    tick(2);
    chk({pcoe, pboe, pbo}, 3'h3);
    wr(1, 0, 8'h0a);
    tick(1);
    chk(pboe, 1'b0);
    @(posedge clk);
    remap <= 1'b1;
    wr(1, 0, 8'h00);
    $display("Test compare done");
  endtask
  task automatic test_pwm;
    @(posedge clk);
    pr <= 8'h03;
    wr(0, 1, 8'h02);
    wr(0, 0, 8'h0c);
    wr(1, 1, 8'h01);
    wr(1, 0, 8'h2c);
    per(16);
    tick(40);
    cnt(16);
    chk(16'(ca), 16'h0008);
    chk(16'(cp), 16'h0006);
    chk({boe, pcoe}, 5'h11);
    @(posedge clk);
    ps <= 2'h1;
    tick(140);
    per(64);
    cnt(64);
    chk(16'(ca), 16'h0020);
    chk(16'(cp), 16'h0018);
    @(posedge clk);
    ps <= 2'h0;
    $display("Test pwm done");
  endtask
  task automatic bc(input logic [1:0] s, input logic [6:0] d, input int ea, input int eb,
    input int ec, input int ed, input logic [3:0] eo);
    @(posedge clk);
    st <= s;
    dly <= d;
    tick(60);
    cnt(16);
    chk(16'(ca), 16'(ea));
    chk(16'(cb), 16'(eb));
    chk(16'(cc), 16'(ec));
    chk(16'(cd), 16'(ed));
    chk(boe, eo);
  endtask
  task automatic test_br;
    bc(ccptsb_pkg::STEER_FWD, 7'h00, 16, 0, 0, 8, 4'hf);
    bc(ccptsb_pkg::STEER_REV, 7'h00, 0, 8, 16, 0, 4'hf);
    bc(ccptsb_pkg::STEER_HALF, 7'h01, 4, 4, 0, 0, 4'hc);
    bc(ccptsb_pkg::STEER_SINGLE, 7'h00, 8, 0, 0, 0, 4'h8);
    $display("Test bridge done");
  endtask
  task automatic summarize;
    $display("Checks %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Mid-run reset clears every register, then writes work again at once
  task automatic test_rst;
    @(posedge clk);
    rst_n <= 1'b0;
    tick(2);
    chk({rg[0].ctrl, rg[1].ctrl}, 16'h0000);
    chk({bo, boe, t2}, 16'h0000);
    chk({mf, pco, pcoe, pbo, pboe}, 16'h0000);
    @(posedge clk);
    rst_n <= 1'b1;
    tick(2);
    wr(0, 1, 8'h3c);
    chk(rg[0].low, 8'h3c);
    $display("Test reset done");
  endtask
  // ************
  // Run
  // ************
  // Inputs start idle; channel two sits on its default pin
  initial begin
    rst_n = 1'b0;
    remap = 1'b1;
    {t1a, s1, sc, sb} = 4'h0;
    {wc, wl, wh, fc, ps, st} = 12'h000;
    {wd, pr} = 16'h0000;
    t1 = 16'h0000;
    dly = 7'h00;
    err_count = 0;
    n_tests = 0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    tick(2);
    test_regs();
    test_cap();
    test_cmp();
    test_pwm();
    test_br();
    test_rst();
    summarize();
  end
  // Watchdog far above the thousand or so cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    $display("Error at %0t: watchdog expired", $time);
    summarize();
  end
endmodule
